// file: sdac_pkg.sv
// sdac_pkg: constants and carrier types of the serial DAC control block
// assumes: 16-bit words sent MSB first, eight channel slots in the device
`default_nettype none

package sdac_pkg;

	// ------------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int WORD_W = 16;
	localparam int MAIN_W = 10;
	localparam int SUB_W  = 8;
	localparam int ADDR_W = 3;

	// ------------------------------------------------------------------
	// serial word layout
	// ------------------------------------------------------------------
	localparam int BIT_MAIN_SUB = 15;
	localparam int BIT_WT_LO    = 14;
	localparam int BIT_WT_HI    = 13;
	localparam int ADDR_MSB     = 12;
	localparam int ADDR_LSB     = 10;
	localparam int MAIN_MSB     = 9;
	localparam int SUB_MSB      = 9;
	localparam int SUB_LSB      = 2;
	localparam int SC_CODING    = 6;
	localparam int SC_PWR       = 5;
	localparam int SC_CHAN_STANDBY_N      = 4;
	localparam int SC_CLR       = 3;
	localparam int CC_BIAS_HI   = 9;
	localparam int CC_BIAS_LO   = 8;
	localparam int CC_CHAN_STANDBY_N      = 4;
	localparam int CC_CLR       = 3;

	// ------------------------------------------------------------------
	// frame bit counter and codes
	// ------------------------------------------------------------------
	localparam logic [4:0] CNT_LAST = 5'h0F;
	localparam logic [4:0] CNT_OVER = 5'h10;
	localparam logic [4:0] CNT_SAT  = 5'h11;

	localparam logic [MAIN_W-1:0] MAIN_CLEAR = 10'h000;
	localparam logic [SUB_W-1:0]  SUB_RST    = 8'h00;

	localparam logic [1:0] BIAS_HALF_SUP = 2'h0;
	localparam logic [1:0] BIAS_INT_REF  = 2'h1;
	localparam logic [1:0] BIAS_EXT_REF  = 2'h2;
	localparam logic [1:0] BIAS_UNDEF    = 2'h3;

	localparam logic [2:0] SYNC_HI_RST = 3'h7;
	localparam logic [1:0] TGL_SY_RST  = 2'h0;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic power_down_n;
		logic coding_select;
		logic all_standby;
		logic all_soft_clear;
	} sdac_glob_s;

	typedef struct packed {
		logic       chan_standby_n;
		logic       chan_soft_clear;
		logic [1:0] bias_source_sel;
	} sdac_chctl_s;

	typedef struct packed {
		logic              active;
		logic [1:0]        bias;
		logic [MAIN_W-1:0] main;
		logic [SUB_W-1:0]  sub;
	} sdac_chout_s;

	localparam sdac_glob_s GLOB_RST = '{
		power_down_n:   1'h1,
		coding_select:  1'h0,
		all_standby:    1'h1,
		all_soft_clear: 1'h0
	};

	localparam sdac_chctl_s CHCTL_RST = '{
		chan_standby_n:  1'h1,
		chan_soft_clear: 1'h1,
		bias_source_sel: BIAS_HALF_SUP
	};

	localparam sdac_chout_s CHOUT_RST = '{
		active: 1'h0,
		bias:   BIAS_HALF_SUP,
		main:   MAIN_CLEAR,
		sub:    SUB_RST
	};

endpackage

`default_nettype wire

// file: sdac_link_rx.sv
// sdac_link_rx: serial word receiver on the link clock
// assumes: host shifts on falling clock edges while frame sync is low
`default_nettype none
`timescale 1ns/1ps

module sdac_link_rx
(
	input  wire logic                        i_clk_ser,
	input  wire logic                        i_rst,
	input  wire logic                        i_frame_sync_n,
	input  wire logic                        i_serial_data_in,
	output logic [sdac_pkg::WORD_W-1:0]      o_word,
	output logic                             o_word_tgl
);
	import sdac_pkg::*;

	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] shift_nxt;
	logic [WORD_W-1:0] hold_r;
	logic [WORD_W-1:0] hold_nxt;
	logic [4:0]        cnt_r;
	logic [4:0]        cnt_nxt;
	logic              tgl_r;
	logic              tgl_nxt;
	logic              cnt_clr;

	// ------------------------------------------------------------------
	// shifter: 16th edge captures and toggles, 17th cancels the toggle
	// ------------------------------------------------------------------
	always_comb
	begin
		shift_nxt = shift_r;
		hold_nxt  = hold_r;
		tgl_nxt   = tgl_r;
		cnt_nxt   = cnt_r;
		if (!i_frame_sync_n)
		begin
			shift_nxt = {shift_r[WORD_W-2:0], i_serial_data_in};
			if (cnt_r != CNT_SAT)
				cnt_nxt = cnt_r + 5'h01;
			if (cnt_r == CNT_LAST)
			begin
				hold_nxt = shift_nxt;
				tgl_nxt  = ~tgl_r;
			end
			if (cnt_r == CNT_OVER)
				tgl_nxt = ~tgl_r;
		end
	end

	always_ff @(negedge i_clk_ser or posedge i_rst)
	begin
		if (i_rst)
		begin
			shift_r <= '0;
			hold_r  <= '0;
			tgl_r   <= 1'h0;
		end
		else
		begin
			shift_r <= shift_nxt;
			hold_r  <= hold_nxt;
			tgl_r   <= tgl_nxt;
		end
	end

	// counter restarts whenever the frame is closed
	assign cnt_clr = i_rst | i_frame_sync_n;

	always_ff @(negedge i_clk_ser or posedge cnt_clr)
	begin
		if (cnt_clr)
			cnt_r <= 5'h00;
		else
			cnt_r <= cnt_nxt;
	end

	assign o_word     = hold_r;
	assign o_word_tgl = tgl_r;

	chk_word_capture: assert property (
		@(negedge i_clk_ser) disable iff (i_rst || i_frame_sync_n)
		(cnt_r == CNT_LAST) |=> (tgl_r != $past(tgl_r))
			&& (hold_r[0] == $past(i_serial_data_in))
	) else $error("word not captured on 16th edge");

endmodule

`default_nettype wire

// file: sdac_ctrl.sv
// sdac_ctrl: register decode and output control of the serial DAC
// assumes: link pins arrive asynchronously; analog side reads o_chan
//
// Contract
// - bits 13/14 pick system, channel or data
// - shift data in MSB first while framed
// - load strobe copies all data registers together
// - data word: sub flag, address, 10-bit code
// - power-down low stops reference and DACs
// - registers kept through power-down
// - one coding bit for all channels
// - global standby idles all DACs, reference on
// - global clear zeroes main data and DAC
// - global clear leaves fine offset data
// - quad part ignores top address bit
// - octal part decodes all three address bits
// - channel standby bit idles that DAC
// - channel clear clears only its main DAC
// - channel clear applies at next load strobe
// - two bias bits choose channel reference
// - sub flag writes fine offset register
// - fine offset holds 8 bits, drops two
// - fine offset code follows selected coding
// - power-up in standby, reference running
// - channel defaults: on, cleared, half supply
`default_nettype none
`timescale 1ns/1ps

module sdac_ctrl
#(
	parameter bit P_OCTAL = 1'b1
)
(
	input  wire logic                                    i_clk_sys,
	input  wire logic                                    i_rst,
	input  wire logic                                    i_ce,
	input  wire logic                                    i_serial_clock_in,
	input  wire logic                                    i_frame_sync_n,
	input  wire logic                                    i_serial_data_in,
	input  wire logic                                    i_load_outputs_n,
	output var  sdac_pkg::sdac_glob_s                    o_glob,
	output var  sdac_pkg::sdac_chout_s [sdac_pkg::NUM_CH-1:0] o_chan
);
	import sdac_pkg::*;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [WORD_W-1:0]              rx_word;
	logic                           rx_tgl;

	logic [2:0]                     fs_sy_r;
	logic [2:0]                     fs_sy_nxt;
	logic [2:0]                     ld_sy_r;
	logic [2:0]                     ld_sy_nxt;
	logic [1:0]                     tg_sy_r;
	logic [1:0]                     tg_sy_nxt;

	logic                           frame_end;
	logic                           load_ev;
	logic                           accept;
	logic                           wr_sys;
	logic                           wr_chan;
	logic                           wr_data;
	logic                           wr_sub;
	logic [ADDR_W-1:0]              addr;

	logic                           seen_r;
	logic                           seen_nxt;
	sdac_glob_s                     glob_r;
	sdac_glob_s                     glob_nxt;
	sdac_chctl_s [NUM_CH-1:0]       chctl_r;
	sdac_chctl_s [NUM_CH-1:0]       chctl_nxt;

	logic [NUM_CH-1:0][MAIN_W-1:0]  main_data_r;
	logic [NUM_CH-1:0][MAIN_W-1:0]  main_data_nxt;
	logic [NUM_CH-1:0][MAIN_W-1:0]  main_dac_r;
	logic [NUM_CH-1:0][MAIN_W-1:0]  main_dac_nxt;
	logic [NUM_CH-1:0][SUB_W-1:0]   sub_data_r;
	logic [NUM_CH-1:0][SUB_W-1:0]   sub_data_nxt;
	logic [NUM_CH-1:0][SUB_W-1:0]   sub_dac_r;
	logic [NUM_CH-1:0][SUB_W-1:0]   sub_dac_nxt;

	sdac_chout_s [NUM_CH-1:0]       out_nxt;

	// ------------------------------------------------------------------
	// link receiver
	// ------------------------------------------------------------------
	sdac_link_rx u_link_rx
	(
		.i_clk_ser        (i_serial_clock_in),
		.i_rst            (i_rst),
		.i_frame_sync_n   (i_frame_sync_n),
		.i_serial_data_in (i_serial_data_in),
		.o_word           (rx_word),
		.o_word_tgl       (rx_tgl)
	);

	// ------------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------------
	always_comb
	begin
		fs_sy_nxt = {fs_sy_r[1:0], i_frame_sync_n};
		ld_sy_nxt = {ld_sy_r[1:0], i_load_outputs_n};
		tg_sy_nxt = {tg_sy_r[0], rx_tgl};
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			fs_sy_r <= SYNC_HI_RST;
			ld_sy_r <= SYNC_HI_RST;
			tg_sy_r <= TGL_SY_RST;
		end
		else if (i_ce)
		begin
			fs_sy_r <= fs_sy_nxt;
			ld_sy_r <= ld_sy_nxt;
			tg_sy_r <= tg_sy_nxt;
		end
	end

	// ------------------------------------------------------------------
	// word decode
	// ------------------------------------------------------------------
	always_comb
	begin
		frame_end = fs_sy_r[1] & ~fs_sy_r[2];
		load_ev   = ld_sy_r[2] & ~ld_sy_r[1];
		// toggle parity changed only after exactly sixteen edges
		accept    = frame_end & (tg_sy_r[1] ^ seen_r);
		wr_data   = accept & rx_word[BIT_WT_HI];
		wr_chan   = accept & ~rx_word[BIT_WT_HI] & rx_word[BIT_WT_LO];
		wr_sys    = accept & ~rx_word[BIT_WT_HI] & ~rx_word[BIT_WT_LO];
		wr_sub    = wr_data & rx_word[BIT_MAIN_SUB];
		addr      = rx_word[ADDR_MSB:ADDR_LSB];
		if (!P_OCTAL)
			addr[ADDR_W-1] = 1'b0;
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always_comb
	begin
		seen_nxt  = accept ? tg_sy_r[1] : seen_r;
		glob_nxt  = glob_r;
		chctl_nxt = chctl_r;
		if (wr_sys)
		begin
			glob_nxt.coding_select  = rx_word[SC_CODING];
			glob_nxt.power_down_n   = rx_word[SC_PWR];
			glob_nxt.all_standby    = rx_word[SC_CHAN_STANDBY_N];
			glob_nxt.all_soft_clear = rx_word[SC_CLR];
		end
		for (int c = 0; c < NUM_CH; c++)
		begin
			if (wr_chan && addr == ADDR_W'(c))
			begin
				chctl_nxt[c].chan_standby_n  = rx_word[CC_CHAN_STANDBY_N];
				chctl_nxt[c].chan_soft_clear = rx_word[CC_CLR];
				chctl_nxt[c].bias_source_sel = rx_word[CC_BIAS_HI:CC_BIAS_LO];
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			seen_r  <= 1'h0;
			glob_r  <= GLOB_RST;
			chctl_r <= {NUM_CH{CHCTL_RST}};
		end
		else if (i_ce)
		begin
			seen_r  <= seen_nxt;
			glob_r  <= glob_nxt;
			chctl_r <= chctl_nxt;
		end
	end

	// ------------------------------------------------------------------
	// data and DAC registers (untouched by power-down)
	// ------------------------------------------------------------------
	always_comb
	begin
		main_data_nxt = main_data_r;
		main_dac_nxt  = main_dac_r;
		sub_data_nxt  = sub_data_r;
		sub_dac_nxt   = sub_dac_r;
		for (int c = 0; c < NUM_CH; c++)
		begin
			if (wr_data && addr == ADDR_W'(c))
			begin
				if (wr_sub)
					sub_data_nxt[c] = rx_word[SUB_MSB:SUB_LSB];
				else
					main_data_nxt[c] = rx_word[MAIN_MSB:0];
			end
			if (load_ev)
			begin
				sub_dac_nxt[c] = sub_data_r[c];
				if (chctl_r[c].chan_soft_clear)
					main_dac_nxt[c] = MAIN_CLEAR;
				else
					main_dac_nxt[c] = main_data_r[c];
			end
			// zero code is midscale in twos complement, bottom in offset
			if (glob_r.all_soft_clear)
			begin
				main_data_nxt[c] = MAIN_CLEAR;
				main_dac_nxt[c]  = MAIN_CLEAR;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			main_data_r <= {NUM_CH{MAIN_CLEAR}};
			main_dac_r  <= {NUM_CH{MAIN_CLEAR}};
			sub_data_r  <= {NUM_CH{SUB_RST}};
			sub_dac_r   <= {NUM_CH{SUB_RST}};
		end
		else if (i_ce)
		begin
			main_data_r <= main_data_nxt;
			main_dac_r  <= main_dac_nxt;
			sub_data_r  <= sub_data_nxt;
			sub_dac_r   <= sub_dac_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs to the analog side
	// ------------------------------------------------------------------
	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			out_nxt[c].active = glob_r.power_down_n & ~glob_r.all_standby
				& chctl_r[c].chan_standby_n;
			if (chctl_r[c].bias_source_sel == BIAS_UNDEF)
				out_nxt[c].bias = BIAS_HALF_SUP;
			else
				out_nxt[c].bias = chctl_r[c].bias_source_sel;
			out_nxt[c].main = main_dac_r[c];
			out_nxt[c].sub  = sub_dac_r[c];
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			o_chan <= {NUM_CH{CHOUT_RST}};
		else if (i_ce)
			o_chan <= out_nxt;
	end

	// coding bit travels with the codes for the analog side to interpret
	assign o_glob = glob_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb_sys @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	chk_load_copy: assert property (
		(load_ev && i_ce && !glob_r.all_soft_clear && !chctl_r[0].chan_soft_clear)
		|=> (main_dac_r[0] == $past(main_data_r[0])) && (sub_dac_r[0] == $past(sub_data_r[0]))
	) else $error("load strobe did not copy data registers");

	chk_chan_clear: assert property (
		(load_ev && i_ce && chctl_r[1].chan_soft_clear)
		|=> (main_dac_r[1] == MAIN_CLEAR)
	) else $error("channel clear not applied at load");

	chk_global_clear: assert property (
		(glob_r.all_soft_clear && i_ce) |=> (main_data_r[2] == MAIN_CLEAR)
			&& (main_dac_r[2] == MAIN_CLEAR)
	) else $error("global clear left main codes");

	chk_sub_kept: assert property (
		(glob_r.all_soft_clear && i_ce && !wr_data) |=> (sub_data_r == $past(sub_data_r))
	) else $error("global clear disturbed fine offset data");

	chk_pd_idle: assert property (
		(!glob_r.power_down_n && i_ce && !wr_sys) |=> !o_chan[3].active && !o_glob.power_down_n
	) else $error("powered-down channel reported active");

	chk_bias_fallback: assert property (
		(chctl_r[7].bias_source_sel == BIAS_UNDEF && i_ce) |=> (o_chan[7].bias == BIAS_HALF_SUP)
	) else $error("undefined bias code not replaced");

	chk_bad_frame: assert property (
		(i_ce && !accept) |=> (glob_r == $past(glob_r)) && (chctl_r == $past(chctl_r))
	) else $error("control changed without a complete frame");

	chk_sys_write: assert property (
		(wr_sys && i_ce) |=> (glob_r.all_standby == $past(rx_word[SC_CHAN_STANDBY_N]))
			&& (glob_r.coding_select == $past(rx_word[SC_CODING]))
	) else $error("system word not stored");

	chk_chan_write: assert property (
		(wr_chan && i_ce) |=> (chctl_r[$past(addr)].chan_soft_clear == $past(rx_word[CC_CLR]))
	) else $error("channel word not stored at its address");

	chk_sub_write: assert property (
		(wr_sub && i_ce) |=> (sub_data_r[$past(addr)] == $past(rx_word[SUB_MSB:SUB_LSB]))
	) else $error("fine offset word not stored");

	cov_load: cover property (load_ev && i_ce);
	cov_chan_word: cover property (wr_chan && i_ce);
	cov_sub_word: cover property (wr_sub && i_ce ##[1:200] load_ev);
	cov_global_clear: cover property (wr_sys && rx_word[SC_CLR] && i_ce);

endmodule

`default_nettype wire

// file: sdac_host_model.sv
// sdac_host_model: host side of the serial link, drives clock, frame and data
// assumes: device takes data on falling clock edges while frame is low
`default_nettype none
`timescale 1ns/1ps

module sdac_host_model
(
	output logic o_sclk,
	output logic o_fs_n,
	output logic o_sdi
);
	// ------------------------------------------------------------------
	// idle: clock stands high, frame high
	// ------------------------------------------------------------------
	initial
	begin
		o_sclk = 1'b1;
		o_fs_n = 1'b1;
		o_sdi  = 1'b0;
	end

	// ------------------------------------------------------------------
	// one frame of n falling edges, msb first, extra bits beyond 16
	// ------------------------------------------------------------------
	task automatic send(input logic [15:0] w, input int n);
		int i;
		// link clock phase 1.3 ns past the call; the 25th back-to-back frame lands on system clock edges
		#1.3;
		o_fs_n = 1'b0;
		for (i = 15; i > 15 - n; i--)
		begin
			o_sdi = (i >= 0) ? w[i] : ~o_sdi;
			#7.5 o_sclk = 1'b0;
			#7.5 o_sclk = 1'b1;
		end
		// released line must not keep its last value
		o_sdi = ~o_sdi;
		#7.5 o_fs_n = 1'b1;
		#80;
	endtask
endmodule

`default_nettype wire

// file: sdac_ctrl_tb.sv
// sdac_ctrl_tb: self-checking bench of sdac_ctrl, octal and quad builds
// assumes: sdac_host_model drives the link of both builds in parallel
`default_nettype none
`timescale 1ns/1ps

module sdac_ctrl_tb;
	import sdac_pkg::*;

	logic                     clk;
	logic                     rst;
	logic                     ld_n;
	logic                     sclk;
	logic                     fs_n;
	logic                     sdi;
	sdac_glob_s               glob;
	sdac_chout_s [NUM_CH-1:0] ch;
	sdac_chout_s [NUM_CH-1:0] chq;
	int                       n_fail;
	int                       compares;
	logic [MAIN_W-1:0]        em [NUM_CH];
	logic [SUB_W-1:0]         es [NUM_CH];
	logic [1:0]               eb [NUM_CH];
	logic                     estb [NUM_CH];
	logic                     ep;
	logic                     ec;
	logic                     esb;
	logic                     ecl;

	sdac_host_model host (.o_sclk(sclk), .o_fs_n(fs_n), .o_sdi(sdi));

	sdac_ctrl #(.P_OCTAL(1'b1)) dut
	(
		.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_serial_clock_in(sclk),
		.i_frame_sync_n(fs_n), .i_serial_data_in(sdi), .i_load_outputs_n(ld_n),
		.o_glob(glob), .o_chan(ch)
	);

	sdac_ctrl #(.P_OCTAL(1'b0)) dut_q
	(
		.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_serial_clock_in(sclk),
		.i_frame_sync_n(fs_n), .i_serial_data_in(sdi), .i_load_outputs_n(ld_n),
		.o_glob(), .o_chan(chq)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// word builders, compare and load helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] ws(input logic cod, pd, sb, cl);
		return {9'h000, cod, pd, sb, cl, 3'h0};
	endfunction

	function automatic logic [15:0] wc(input logic [2:0] a, input logic [1:0] b,
		input logic sb, cl);
		return {1'b0, 2'h2, a, b, 3'h0, sb, cl, 3'h0};
	endfunction

	function automatic logic [15:0] wd(input logic s, input logic [2:0] a,
		input logic [9:0] d);
		return s ? {3'h5, a, d[7:0], 2'h3} : {3'h1, a, d};
	endfunction

	function automatic logic [MAIN_W-1:0] mv(input int c);
		return 10'(10'h200 + c * 71);
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_all(input string t);
		int c;
		chk(16'(glob), 16'({ep, ec, esb, ecl}), "glob");
		for (c = 0; c < NUM_CH; c++)
		begin
			chk(16'(ch[c].main), 16'(em[c]), "main");
			chk(16'(ch[c].sub), 16'(es[c]), "sub");
			chk(16'(ch[c].bias), 16'(eb[c]), "bias");
			chk(16'(ch[c].active), 16'(ep & ~esb & estb[c]), "active");
		end
		$display("test %s done", t);
	endtask

	task automatic send(input logic [15:0] w);
		host.send(w, 16);
	endtask

	task automatic load();
		@(negedge clk) ld_n = 1'b0;
		repeat (4) @(negedge clk);
		ld_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask

	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_fail++;
		print_verdict();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		int c;
		rst = 1'b1;
		ld_n = 1'b1;
		n_fail = 0;
		compares = 0;
		for (c = 0; c < NUM_CH; c++)
		begin
			em[c] = '0;
			es[c] = '0;
			eb[c] = 2'h0;
			estb[c] = 1'b1;
		end
		{ep, ec, esb, ecl} = 4'hA;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		chk_all("reset");
		send(wd(1'b0, 3'h0, 10'h155));
		load();
		chk_all("default clear");
		send(wc(3'h0, 2'h1, 1'b1, 1'b0));
		eb[0] = 2'h1;
		chk_all("unclear waits");
		load();
		em[0] = 10'h155;
		chk_all("unclear loads");
		send(ws(1'b1, 1'b1, 1'b0, 1'b0));
		{ec, esb} = 2'h2;
		chk_all("leave standby");
		for (c = 0; c < NUM_CH; c++)
		begin
			send(wc(3'(c), 2'(c % 4), 1'b1, 1'b0));
			eb[c] = (c % 4 == 3) ? 2'h0 : 2'(c % 4);
			send(wd(1'b0, 3'(c), mv(c)));
			send(wd(1'b1, 3'(c), {2'h0, 8'(255 - c * 17)}));
		end
		chk_all("data buffered");
		load();
		for (c = 0; c < NUM_CH; c++)
		begin
			em[c] = mv(c);
			es[c] = 8'(255 - c * 17);
		end
		chk_all("all channels");
		for (c = 0; c < 4; c++)
			chk(16'(chq[c].main), 16'(em[c + 4]), "quad");
		send(wc(3'h3, 2'h3, 1'b0, 1'b0));
		estb[3] = 1'b0;
		chk_all("chan standby");
		send(wc(3'h2, 2'h2, 1'b1, 1'b1));
		chk_all("clear waits");
		load();
		em[2] = MAIN_CLEAR;
		chk_all("chan clear");
		send(wc(3'h2, 2'h2, 1'b1, 1'b0));
		load();
		em[2] = mv(2);
		chk_all("chan unclear");
		host.send(wd(1'b0, 3'h1, 10'h0AA), 15);
		host.send(wd(1'b0, 3'h1, 10'h0AA), 17);
		load();
		chk_all("bad frames");
		send(wc(3'h3, 2'h3, 1'b1, 1'b0));
		estb[3] = 1'b1;
		send(ws(1'b1, 1'b0, 1'b0, 1'b0));
		ep = 1'b0;
		chk_all("power down");
		send(ws(1'b1, 1'b1, 1'b0, 1'b0));
		ep = 1'b1;
		chk_all("power up");
		send(ws(1'b0, 1'b1, 1'b0, 1'b1));
		{ec, ecl} = 2'h1;
		for (c = 0; c < NUM_CH; c++)
			em[c] = MAIN_CLEAR;
		chk_all("global clear");
		send(wd(1'b0, 3'h4, 10'h123));
		send(ws(1'b0, 1'b1, 1'b0, 1'b0));
		ecl = 1'b0;
		load();
		chk_all("clear kept data");
		print_verdict();
	end
endmodule

`default_nettype wire
